// *** rtl/psc_top.sv ***
// Synthesizer configuration, lock detection, status flags and clock ratios.
// Assumes an APB master, clock_i at 10 MHz and one-cycle tick inputs from the oscillators.
//
// The APB register port is this design's own decision.
`include "psc_defines.svh"

module psc_top #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic sys_reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Clock ticks and events
  input wire logic crystal_tick_i,
  input wire logic irc_tick_i,
  input wire logic vco_tick_i,
  input wire logic periodic_tick_i,
  input wire logic brownout_event_i,
  input wire logic bad_addr_event_i,
  input wire logic full_stop_i,
  // Clock outputs
  output logic ref_tick_o,
  output logic synth_tick_o,
  output logic bus_tick_o,
  output logic synth_select_o,
  // Analogue settings
  output logic [1:0] vco_range_o,
  output logic [1:0] filter_range_o,
  output logic [7:0] loop_ratio_o,
  output logic can_osc_en_o,
  // Interrupt requests
  output logic periodic_irq_o,
  output logic settle_irq_o,
  output logic osc_irq_o
);
  psc_pkg::psc_apb_state_t state_q;
  logic [7:0] mult_q;
  logic [7:0] presc_q;
  logic [7:0] outdiv_q;
  logic [7:0] irqen_q;
  logic [7:0] ctrl_q;
  logic periodic_flag_q;
  logic poweron_flag_q;
  logic brownout_flag_q;
  logic settle_flag_q;
  logic bad_addr_flag_q;
  logic osc_flag_q;
  logic lock_q;
  logic lock_prev_q;
  logic osc_qual_q;
  logic osc_qual_prev_q;
  logic in_tol_q;
  logic [7:0] vco_cnt_q;
  logic [7:0] prdata_q;
  logic [7:0] target;
  logic [7:0] flags;
  logic [7:0] wbyte;
  logic [9:0] idx;
  logic wr_done;
  logic wr_cfg_ok;
  logic cfg_write;
  logic pre_pulse;
  logic synth_pulse;
  logic bus_pulse;
  logic bus_src;
  logic [7:0] synth_div;

  function automatic logic mapped(input logic [9:0] i);
    mapped = (i == `PSC_IDX_MULT) || (i == `PSC_IDX_PRESC) || (i == `PSC_IDX_OUTDIV) ||
             (i == `PSC_IDX_FLAGS) || (i == `PSC_IDX_IRQEN) || (i == `PSC_IDX_CTRL);
  endfunction

  // Write-one clear, but a hardware set in the same cycle wins
  function automatic logic w1c(input logic q, input logic set, input logic clr);
    w1c = set | (q & ~clr);
  endfunction

  assign idx = paddr_i[11:2];
  assign wbyte = pwdata_i[7:0];
  // Write happens at the edge that samples pready high
  assign wr_done = psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0] && mapped(idx);
  assign wr_cfg_ok = !ctrl_q[`PSC_C_GUARD] && ctrl_q[`PSC_C_SELECT];
  assign cfg_write = wr_done && wr_cfg_ok &&
                     ((idx == `PSC_IDX_MULT) || (idx == `PSC_IDX_PRESC));
  // expected VCO ticks per reference period
  assign target = {1'b0, mult_q[`PSC_MULT_MSB:0], 1'b0} + 8'h02;
  assign flags = {periodic_flag_q, poweron_flag_q, brownout_flag_q, settle_flag_q,
                  lock_q, bad_addr_flag_q, osc_flag_q, osc_qual_q};

  // APB phase: one wait cycle so read data and pready leave flip-flops
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= psc_pkg::PSC_APB_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_q <= 8'h00;
    end else begin
      unique case (state_q)
        psc_pkg::PSC_APB_IDLE: begin
          if (psel_i && penable_i) begin
            state_q <= psc_pkg::PSC_APB_RESP;
            pready_o <= 1'b1;
            pslverr_o <= !mapped(idx);
            unique case (idx)
              `PSC_IDX_MULT: prdata_q <= mult_q;
              `PSC_IDX_PRESC: prdata_q <= presc_q;
              `PSC_IDX_OUTDIV: prdata_q <= outdiv_q;
              `PSC_IDX_FLAGS: prdata_q <= flags;
              `PSC_IDX_IRQEN: prdata_q <= irqen_q;
              `PSC_IDX_CTRL: prdata_q <= ctrl_q;
              default: prdata_q <= 8'h00;
            endcase
          end
        end
        psc_pkg::PSC_APB_RESP: begin
          state_q <= psc_pkg::PSC_APB_IDLE;
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
          prdata_q <= 8'h00;
        end
      endcase
    end
  end

  assign prdata_o = {24'h000000, prdata_q};

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mult_q <= `PSC_RST_MULT;
      presc_q <= `PSC_RST_PRESC;
    end else if (sys_reset_i) begin
      mult_q <= `PSC_RST_MULT;
      presc_q <= `PSC_RST_PRESC;
    end else if (wr_done && wr_cfg_ok) begin
      if (idx == `PSC_IDX_MULT) begin
        mult_q <= wbyte & 8'hff;
      end
      // Unused prescaler bits stay zero
      if (idx == `PSC_IDX_PRESC) begin
        presc_q <= {wbyte[7:`PSC_RANGE_LSB], 2'h0, wbyte[`PSC_PRESC_MSB:0]};
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      outdiv_q <= `PSC_RST_OUTDIV;
    end else if (sys_reset_i) begin
      outdiv_q <= `PSC_RST_OUTDIV;
    end else if (wr_done && ctrl_q[`PSC_C_SELECT] && idx == `PSC_IDX_OUTDIV) begin
      outdiv_q <= {3'h0, wbyte[`PSC_OUTDIV_MSB:0]};
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irqen_q <= `PSC_RST_IRQEN;
    end else if (sys_reset_i) begin
      irqen_q <= `PSC_RST_IRQEN;
    end else if (wr_done && idx == `PSC_IDX_IRQEN) begin
      irqen_q <= {wbyte[`PSC_F_PERIODIC], 2'h0, wbyte[`PSC_F_SETTLE], 2'h0,
                  wbyte[`PSC_F_OSCCHG], 1'b0};
    end
  end

  // Guard is always writable; select and oscillator enable only while unguarded
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= `PSC_RST_CTRL;
    end else if (sys_reset_i) begin
      ctrl_q <= `PSC_RST_CTRL;
    end else begin
      if (wr_done && idx == `PSC_IDX_CTRL) begin
        ctrl_q[`PSC_C_GUARD] <= wbyte[`PSC_C_GUARD];
        if (!ctrl_q[`PSC_C_GUARD]) begin
          ctrl_q[`PSC_C_OSCEN] <= wbyte[`PSC_C_OSCEN];
          // Select may drop to 0 only with a qualified oscillator
          ctrl_q[`PSC_C_SELECT] <= wbyte[`PSC_C_SELECT] || !osc_qual_q;
        end
      end
      if (!osc_qual_q || full_stop_i) begin
        ctrl_q[`PSC_C_SELECT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_tick_o <= 1'b0;
    end else begin
      ref_tick_o <= ctrl_q[`PSC_C_OSCEN] ? pre_pulse : irc_tick_i;
    end
  end

  psc_clkdiv #(.W(8)) u_prescale (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_i(crystal_tick_i),
    .div_i({4'h0, presc_q[`PSC_PRESC_MSB:0]}),
    .pulse_o(pre_pulse)
  );

  // count VCO ticks per reference period against the target
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vco_cnt_q <= 8'h00;
      in_tol_q <= 1'b0;
    end else if (cfg_write) begin
      vco_cnt_q <= 8'h00;
      in_tol_q <= 1'b0;
    end else if (ref_tick_o) begin
      vco_cnt_q <= {7'h00, vco_tick_i};
      in_tol_q <= (vco_cnt_q + `PSC_LOCK_TOL >= target) &&
                  (vco_cnt_q <= target + `PSC_LOCK_TOL);
    end else if (vco_tick_i && vco_cnt_q != 8'hff) begin
      vco_cnt_q <= vco_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= 1'b0;
      osc_qual_q <= 1'b0;
    end else if (cfg_write) begin
      lock_q <= 1'b0;
      osc_qual_q <= 1'b0;
    end else begin
      lock_q <= in_tol_q;
      // qualification needs lock; full stop clears
      osc_qual_q <= in_tol_q && lock_q && ctrl_q[`PSC_C_OSCEN] && !full_stop_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_prev_q <= 1'b0;
      osc_qual_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_q;
      osc_qual_prev_q <= osc_qual_q;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      periodic_flag_q <= 1'b0;
      settle_flag_q <= 1'b0;
      osc_flag_q <= 1'b0;
    end else if (sys_reset_i) begin
      periodic_flag_q <= 1'b0;
      settle_flag_q <= 1'b0;
      osc_flag_q <= 1'b0;
    end else begin
      periodic_flag_q <= w1c(periodic_flag_q, periodic_tick_i,
                             wr_done && idx == `PSC_IDX_FLAGS && wbyte[`PSC_F_PERIODIC]);
      settle_flag_q <= w1c(settle_flag_q, lock_q ^ lock_prev_q,
                           wr_done && idx == `PSC_IDX_FLAGS && wbyte[`PSC_F_SETTLE]);
      osc_flag_q <= w1c(osc_flag_q, osc_qual_q ^ osc_qual_prev_q,
                        wr_done && idx == `PSC_IDX_FLAGS && wbyte[`PSC_F_OSCCHG]);
    end
  end

  // reset cause flags survive system reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      poweron_flag_q <= 1'b1;
      brownout_flag_q <= 1'b1;
      bad_addr_flag_q <= 1'b0;
    end else begin
      poweron_flag_q <= w1c(poweron_flag_q, 1'b0,
                            wr_done && idx == `PSC_IDX_FLAGS && wbyte[`PSC_F_POWERON]);
      brownout_flag_q <= w1c(brownout_flag_q, brownout_event_i,
                             wr_done && idx == `PSC_IDX_FLAGS && wbyte[`PSC_F_BROWNOUT]);
      bad_addr_flag_q <= w1c(bad_addr_flag_q, bad_addr_event_i,
                             wr_done && idx == `PSC_IDX_FLAGS && wbyte[`PSC_F_BADADDR]);
    end
  end

  // unlocked output runs at VCO over 4
  assign synth_div = lock_q ? outdiv_q : `PSC_UNLOCK_DIV;

  psc_clkdiv #(.W(8)) u_output_divider_field (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_i(vco_tick_i),
    .div_i(synth_div),
    .pulse_o(synth_pulse)
  );

  // bus clock is half the selected source
  assign bus_src = ctrl_q[`PSC_C_SELECT] ? synth_pulse : crystal_tick_i;

  psc_clkdiv #(.W(8)) u_busdiv (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_i(bus_src),
    .div_i(`PSC_BUS_DIV),
    .pulse_o(bus_pulse)
  );

  // Registered copies keep every output on a flip-flop
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      synth_tick_o <= 1'b0;
      bus_tick_o <= 1'b0;
      synth_select_o <= 1'b1;
      vco_range_o <= 2'h0;
      filter_range_o <= `PSC_FILTER_LOW;
      loop_ratio_o <= 8'h02;
      can_osc_en_o <= 1'b0;
    end else begin
      synth_tick_o <= synth_pulse;
      bus_tick_o <= bus_pulse;
      synth_select_o <= ctrl_q[`PSC_C_SELECT];
      vco_range_o <= mult_q[7:`PSC_RANGE_LSB];
      filter_range_o <= ctrl_q[`PSC_C_OSCEN] ? presc_q[7:`PSC_RANGE_LSB] : `PSC_FILTER_LOW;
      // loop ratio 2 x (field + 1)
      loop_ratio_o <= target;
      can_osc_en_o <= osc_qual_q;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      periodic_irq_o <= 1'b0;
      settle_irq_o <= 1'b0;
      osc_irq_o <= 1'b0;
    end else begin
      periodic_irq_o <= periodic_flag_q && irqen_q[`PSC_F_PERIODIC];
      settle_irq_o <= settle_flag_q && irqen_q[`PSC_F_SETTLE];
      osc_irq_o <= osc_flag_q && irqen_q[`PSC_F_OSCCHG];
    end
  end
endmodule

// *** rtl/psc_defines.svh ***
// Register map, field layout, reset values and fixed ratios for the synthesizer config block.
// Assumes an APB master with 32-bit data; only the low byte of each word is used.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// Register indices; byte address is four times the index
`define PSC_IDX_MULT 10'h034
`define PSC_IDX_PRESC 10'h035
`define PSC_IDX_OUTDIV 10'h036
`define PSC_IDX_FLAGS 10'h037
`define PSC_IDX_IRQEN 10'h038
`define PSC_IDX_CTRL 10'h03a

// Field layout
`define PSC_MULT_MSB 5
`define PSC_RANGE_LSB 6
`define PSC_PRESC_MSB 3
`define PSC_OUTDIV_MSB 4
`define PSC_F_PERIODIC 7
`define PSC_F_POWERON 6
`define PSC_F_BROWNOUT 5
`define PSC_F_SETTLE 4
`define PSC_F_LOCK 3
`define PSC_F_BADADDR 2
`define PSC_F_OSCCHG 1
`define PSC_F_OSCQUAL 0
`define PSC_C_SELECT 7
`define PSC_C_OSCEN 1
`define PSC_C_GUARD 0

// Reset values
`define PSC_RST_MULT 8'h00
`define PSC_RST_PRESC 8'h00
`define PSC_RST_OUTDIV 8'h00
`define PSC_RST_IRQEN 8'h00
`define PSC_RST_CTRL 8'h80

// Fixed ratios
`define PSC_UNLOCK_DIV 8'h03
`define PSC_BUS_DIV 8'h01
`define PSC_FILTER_LOW 2'h0
`define PSC_LOCK_TOL 8'h01

`endif

// *** rtl/psc_pkg.sv ***
// Types shared by the synthesizer config block.
// Assumes psc_defines.svh carries all numeric constants.
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_APB_IDLE = 2'b01,
    PSC_APB_RESP = 2'b10
  } psc_apb_state_t;
endpackage

// *** rtl/psc_clkdiv.sv ***
// Tick divider: one output pulse per (div_i + 1) input ticks.
// Assumes tick_i is a one-cycle enable on clock_i.
module psc_clkdiv #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Ticks
  input wire logic tick_i,
  input wire logic [W-1:0] div_i,
  output logic pulse_o
);
  logic [W-1:0] count_q;

  // Shrinking the ratio mid-count wraps at once instead of overrunning
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= '0;
    end else if (tick_i) begin
      if (count_q >= div_i) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= tick_i && (count_q >= div_i);
    end
  end
endmodule

// *** verif/psc_top_asserts.sv ***
// Port-level checks for the synthesizer config block.
// Assumes it is bound onto psc_top and sees only its ports.
module psc_top_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic sys_reset_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Status and settings
  input wire logic full_stop_i,
  input wire logic synth_select_o,
  input wire logic [1:0] vco_range_o,
  input wire logic [1:0] filter_range_o,
  input wire logic [7:0] loop_ratio_o,
  input wire logic can_osc_en_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic upd;
  // Settings may only move after a completed write or a system reset
  assign upd = (psel_i && penable_i && pwrite_i && pready_o) || sys_reset_i;

  property p_ready_wait;
    $rose(penable_i) && psel_i |=> pready_o;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no answer after one wait");
  property p_ready_access;
    pready_o |-> psel_i && penable_i;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("answer outside access");
  property p_err_zero;
    pslverr_o |-> prdata_o == 32'h0 && pready_o;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error with data");
  property p_byte_wide;
    pready_o |-> prdata_o[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("upper read bits set");
  property p_ratio;
    loop_ratio_o[0] == 1'b0 && loop_ratio_o != 8'h00 && loop_ratio_o <= 8'h80;
  endproperty
  a_ratio: assert property (p_ratio) else $error("loop ratio out of range");
  property p_range_guard;
    !$stable(vco_range_o) || !$stable(filter_range_o) |-> $past(upd) || $past(upd, 2);
  endproperty
  a_range_guard: assert property (p_range_guard) else $error("setting moved alone");
  property p_stop_qual;
    full_stop_i [*3] |-> !can_osc_en_o;
  endproperty
  a_stop_qual: assert property (p_stop_qual) else $error("qualified in full stop");
  property p_unqual_select;
    !can_osc_en_o [*3] |-> synth_select_o;
  endproperty
  a_unqual_select: assert property (p_unqual_select) else $error("select not forced");
  property p_stop_select;
    full_stop_i [*4] |-> synth_select_o;
  endproperty
  a_stop_select: assert property (p_stop_select) else $error("select low in stop");
endmodule

bind psc_top psc_top_asserts u_chk (.clock_i(clock_i), .rstn_i(rstn_i),
  .sys_reset_i(sys_reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .full_stop_i(full_stop_i), .synth_select_o(synth_select_o), .vco_range_o(vco_range_o),
  .filter_range_o(filter_range_o), .loop_ratio_o(loop_ratio_o),
  .can_osc_en_o(can_osc_en_o));

// *** verif/psc_top_bench.sv ***
// Self-checking bench for the synthesizer config block.
// Assumes psc_top with its checker bound on; one 10 MHz clock.
`include "psc_defines.svh"

module psc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] MULT = {`PSC_IDX_MULT, 2'b00};
  localparam logic [11:0] PRESC = {`PSC_IDX_PRESC, 2'b00};
  localparam logic [11:0] OUTDIV = {`PSC_IDX_OUTDIV, 2'b00};
  localparam logic [11:0] FLAGS = {`PSC_IDX_FLAGS, 2'b00};
  localparam logic [11:0] IRQEN = {`PSC_IDX_IRQEN, 2'b00};
  localparam logic [11:0] CTRL = {`PSC_IDX_CTRL, 2'b00};
  logic clock_i = 0, rstn_i = 0, sys_reset_i = 0, run = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o, err;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic crystal_tick_i = 0, vco_tick_i = 0, irc_tick_i = 0, periodic_tick_i = 0;
  logic full_stop_i = 0;
  logic brownout_event_i = 0, bad_addr_event_i = 0;
  logic ref_tick_o, synth_tick_o, bus_tick_o, synth_select_o, can_osc_en_o;
  logic periodic_irq_o, settle_irq_o, osc_irq_o;
  logic [1:0] vco_range_o, filter_range_o, cyc = 0;
  logic [7:0] loop_ratio_o;
  int fails = 0, samples_checked = 0;
  // Ordinary cases: address, write data, expected read-back
  logic [11:0] t_a [4] = '{MULT, PRESC, OUTDIV, IRQEN};
  logic [7:0] t_w [4] = '{8'h7f, 8'hff, 8'hff, 8'hff};
  logic [7:0] t_e [4] = '{8'h7f, 8'hcf, 8'h1f, 8'h92};

  psc_top DUT (.clock_i(clock_i), .rstn_i(rstn_i), .sys_reset_i(sys_reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .crystal_tick_i(crystal_tick_i), .irc_tick_i(irc_tick_i),
    .vco_tick_i(vco_tick_i), .periodic_tick_i(periodic_tick_i),
    .brownout_event_i(brownout_event_i), .bad_addr_event_i(bad_addr_event_i),
    .full_stop_i(full_stop_i), .ref_tick_o(ref_tick_o), .synth_tick_o(synth_tick_o),
    .bus_tick_o(bus_tick_o), .synth_select_o(synth_select_o), .vco_range_o(vco_range_o),
    .filter_range_o(filter_range_o), .loop_ratio_o(loop_ratio_o),
    .can_osc_en_o(can_osc_en_o), .periodic_irq_o(periodic_irq_o),
    .settle_irq_o(settle_irq_o), .osc_irq_o(osc_irq_o));

  always #50 clock_i = ~clock_i;

  // Two VCO ticks per reference period matches a ratio of 2
  always @(posedge clock_i) begin
    cyc <= cyc + 2'd1;
    vco_tick_i <= run & cyc[0];
    // Crystal at half clock; prescaler 1 gives the same reference period
    crystal_tick_i <= run & cyc[0];
    irc_tick_i <= run & (cyc == 2'd0);
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  // Lock with no further ticks, so only the write can clear it
  task automatic relock(input logic [11:0] a);
    run <= 1'b1;
    repeat (40) @(posedge clock_i);
    run <= 1'b0;
    repeat (4) @(posedge clock_i);
    apb(0, FLAGS, 0);
    chk("lock flags", 32'h18, rd & 32'h18);
    apb(1, a, 0);
    apb(0, FLAGS, 0);
  endtask

  // Counts over 64 cycles once ticks and lock have settled
  task automatic tick_count(input int es, input int eb, input int er);
    int s = 0;
    int b = 0;
    int r = 0;
    run <= 1'b1;
    repeat (40) @(posedge clock_i);
    repeat (64) begin
      @(posedge clock_i);
      s += synth_tick_o;
      b += bus_tick_o;
      r += ref_tick_o;
    end
    run <= 1'b0;
    chk("synth ticks", es, s);
    chk("bus ticks", eb, b);
    chk("ref ticks", er, r);
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    end_sim;
  end

  initial begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    apb(0, FLAGS, 0);
    chk("reset flags", 32'h60, rd);
    done("reset");
    relock(MULT);
    chk("mult write", 32'h0, rd & 32'h09);
    relock(PRESC);
    chk("presc write", 32'h0, rd & 32'h09);
    done("lock");
    for (int i = 0; i < 4; i++) begin
      apb(1, t_a[i], {24'h0, t_w[i]});
      apb(0, t_a[i], 0);
      chk("table", {24'h0, t_e[i]}, rd);
    end
    chk("ratio", 32'h80, {24'h0, loop_ratio_o});
    chk("vco range", 32'h1, {30'h0, vco_range_o});
    chk("filter", 32'h0, {30'h0, filter_range_o});
    done("table");
    apb(1, FLAGS, 32'hff);
    apb(0, FLAGS, 0);
    chk("clear ones", 32'h0, rd & 32'hf6);
    @(posedge clock_i);
    periodic_tick_i <= 1'b1;
    brownout_event_i <= 1'b1;
    bad_addr_event_i <= 1'b1;
    @(posedge clock_i);
    periodic_tick_i <= 1'b0;
    brownout_event_i <= 1'b0;
    bad_addr_event_i <= 1'b0;
    apb(0, FLAGS, 0);
    chk("events", 32'ha4, rd & 32'hb4);
    chk("periodic irq", 32'h1, {31'h0, periodic_irq_o});
    chk("settle irq", 32'h0, {31'h0, settle_irq_o});
    apb(1, FLAGS, 32'h0);
    apb(0, FLAGS, 0);
    chk("write zero", 32'ha4, rd & 32'ha4);
    apb(1, IRQEN, 32'h0);
    repeat (2) @(posedge clock_i);
    chk("masked irq", 32'h0, {31'h0, periodic_irq_o});
    done("flags");
    sys_reset_i <= 1'b1;
    @(posedge clock_i);
    sys_reset_i <= 1'b0;
    apb(0, FLAGS, 0);
    chk("sys reset", 32'h24, rd & 32'he4);
    apb(1, CTRL, 32'h81);
    apb(1, MULT, 32'h15);
    apb(0, MULT, 0);
    chk("guarded", 32'h0, rd);
    apb(1, CTRL, 32'h80);
    apb(1, MULT, 32'h15);
    apb(0, MULT, 0);
    chk("unguarded", 32'h15, rd);
    apb(0, 12'hfc, 0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    done("guard");
    tick_count(8, 4, 16);
    apb(1, MULT, 32'h0);
    apb(1, OUTDIV, 32'h1);
    tick_count(16, 8, 16);
    done("ticks");
    apb(1, CTRL, 32'h82);
    apb(1, PRESC, 32'h41);
    tick_count(16, 8, 16);
    chk("crystal filter", 32'h1, {30'h0, filter_range_o});
    apb(0, FLAGS, 0);
    chk("qualified", 32'h1b, rd & 32'h1b);
    apb(1, IRQEN, 32'h12);
    repeat (2) @(posedge clock_i);
    chk("settle irq on", 32'h1, {31'h0, settle_irq_o});
    chk("osc irq on", 32'h1, {31'h0, osc_irq_o});
    apb(1, CTRL, 32'h02);
    apb(1, OUTDIV, 32'h5);
    apb(0, OUTDIV, 0);
    chk("divider locked out", 32'h1, rd);
    apb(1, MULT, 32'h15);
    apb(0, MULT, 0);
    chk("mult locked out", 32'h0, rd);
    chk("select low", 32'h0, {31'h0, synth_select_o});
    done("osc");
    full_stop_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("stop qual", 32'h0, {31'h0, can_osc_en_o});
    chk("stop select", 32'h1, {31'h0, synth_select_o});
    full_stop_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("requalified", 32'h1, {31'h0, can_osc_en_o});
    apb(1, MULT, 32'h0);
    apb(0, FLAGS, 0);
    chk("qual cleared", 32'h0, rd & 32'h09);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    apb(0, FLAGS, 0);
    chk("power on", 32'h60, rd & 32'h64);
    done("stop");
    end_sim;
  end
endmodule
